/* File: include/plm_pkg.sv */
// package: register map, reset values and carrier types for the port latch and match block
package plm_pkg;
  // special-function register addresses
  localparam logic [7:0] PORT0_LATCH_ADDR  = 8'h80;
  localparam logic [7:0] PORT1_LATCH_ADDR  = 8'h90;
  localparam logic [7:0] PORT2_LATCH_ADDR  = 8'hA0;
  localparam logic [7:0] PORT3_LATCH_ADDR  = 8'hB0;
  localparam logic [7:0] PORT4_LATCH_ADDR  = 8'hB5;
  localparam logic [7:0] PORT0_SKIP_ADDR   = 8'hD4;
  localparam logic [7:0] PORT1_SKIP_ADDR   = 8'hD5;
  localparam logic [7:0] PORT2_SKIP_ADDR   = 8'hD6;
  localparam logic [7:0] PORT3_SKIP_ADDR   = 8'hDF;
  localparam logic [7:0] DRIVE0_ADDR       = 8'hA4;
  localparam logic [7:0] KIND0_ADDR        = 8'hF1;
  localparam logic [7:0] CMP_VALUE0_ADDR   = 8'hD7;
  localparam logic [7:0] CMP_MASK0_ADDR    = 8'hC7;
  localparam logic [7:0] PIN_ASSIGN_ADDR   = 8'hE2;
  localparam logic [7:0] IRQ_ENABLE_ADDR   = 8'hE7;
  // reset values
  localparam logic [7:0] LATCH_RESET       = 8'hFF;
  localparam logic [7:0] PORT4_RESET       = 8'h7F;
  localparam logic [7:0] SKIP_RESET        = 8'h00;
  localparam logic [7:0] DRIVE_RESET       = 8'h00;
  localparam logic [7:0] KIND_RESET        = 8'hFF;
  localparam logic [7:0] CMP_VALUE_RESET   = 8'hFF;
  localparam logic [7:0] CMP_MASK_RESET    = 8'h00;
  localparam logic [7:0] PORT4_WRITE_MASK  = 8'h7F;
  localparam logic [7:0] CTRL_RESET        = 8'h00;
  localparam logic [7:0] RDATA_RESET       = 8'h00;
  // field positions
  localparam int         PIN_ASSIGNER_BIT  = 6;
  localparam int         PATTERN_IRQ_BIT   = 1;
  localparam int         NUM_PORTS         = 5;
  localparam int         NUM_MATCH_PORTS   = 3;
  // special-function bus request
  typedef struct packed {
    logic       wr;       // byte write
    logic       rd;       // byte read
    logic       bit_wr;   // single-bit write
    logic       rmw;      // read phase of read-modify-write
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } plm_sfr_req_t;
  // per-pin drive of the pads
  typedef struct packed {
    logic [39:0] out;
    logic [39:0] oe;
  } plm_pad_t;
endpackage

/* File: design/plm_port_latch_and_match.sv */
// port latches, pin readback, skip bits and port match event logic
`timescale 1ns/1ps
`default_nettype none
module plm_port_latch_and_match #(
  parameter int PORT_W = 8
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST_B,
  input  wire plm_pkg::plm_sfr_req_t SFR_REQ,
  output logic [7:0]                 SFR_RDATA,
  output logic                       SFR_HIT,
  input  wire logic [39:0]           PIN_IN,
  output plm_pkg::plm_pad_t          PAD,
  output logic [31:0]                CROSSBAR_SKIP,
  output logic [39:0]                DIGITAL_IN_EN,
  output logic                       PIN_ASSIGNER_ON,
  output logic                       PORT_MATCH,
  output logic                       PATTERN_IRQ,
  output logic                       OSC_WAKE
);

  localparam int NP = plm_pkg::NUM_PORTS;

  logic [NP-1:0][PORT_W-1:0] latch_q;
  logic [NP-1:0][PORT_W-1:0] drive_q;
  logic [NP-1:0][PORT_W-1:0] kind_q;
  logic [3:0][PORT_W-1:0]    skip_q;
  logic [2:0][PORT_W-1:0]    cmp_val_q;
  logic [2:0][PORT_W-1:0]    cmp_msk_q;
  logic [7:0]                assign_q;
  logic [7:0]                irq_en_q;
  logic [NP-1:0][PORT_W-1:0] pin_view;
  logic [7:0]                rdata_d;
  logic                      hit_d;
  logic [2:0]                mismatch;
  logic [7:0]                bit_onehot;
  logic [NP-1:0]             latch_wr;
  logic [NP-1:0]             latch_bit_wr;
  logic [NP-1:0]             drive_wr;
  logic [NP-1:0]             kind_wr;
  logic [3:0]                skip_wr;
  logic [2:0]                cmp_val_wr;
  logic [2:0]                cmp_msk_wr;
  logic                      assign_wr;
  logic                      irq_en_wr;
  logic                      rd_any;
  logic                      match_any;

  // bit select as a one-hot mask for single-bit writes
  assign bit_onehot = 8'h01 << SFR_REQ.bit_sel;
  // both read kinds load the answer register
  assign rd_any     = SFR_REQ.rd | SFR_REQ.rmw;

  // per-port latch, drive mode, input kind; port 4 gets its own address, reset value, write mask and no bit writes
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      localparam logic [7:0] LADDR = (gp == 4) ? plm_pkg::PORT4_LATCH_ADDR :
                                     8'(plm_pkg::PORT0_LATCH_ADDR + 8'(gp * 16));
      localparam logic [7:0] RST_V = (gp == 4) ? plm_pkg::PORT4_RESET :
                                     plm_pkg::LATCH_RESET;
      localparam logic [7:0] WMSK  = (gp == 4) ? plm_pkg::PORT4_WRITE_MASK : 8'hFF;
      // port 4 has no bit address, so bit writes never reach it
      localparam bit         BITOK = (gp != 4);

      // write strobes; a byte write outranks a bit write in the same cycle
      assign latch_wr[gp]     = SFR_REQ.wr && (SFR_REQ.addr == LADDR);
      assign latch_bit_wr[gp] = BITOK && SFR_REQ.bit_wr && !SFR_REQ.wr &&
                                (SFR_REQ.addr == LADDR);
      assign drive_wr[gp]     = SFR_REQ.wr &&
                                (SFR_REQ.addr == 8'(plm_pkg::DRIVE0_ADDR + 8'(gp)));
      assign kind_wr[gp]      = SFR_REQ.wr &&
                                (SFR_REQ.addr == 8'(plm_pkg::KIND0_ADDR + 8'(gp)));

      // output latch; a bit write rebuilds the byte from the latch, never the pins
      always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
          latch_q[gp] <= RST_V;
        end else if (latch_wr[gp]) begin
          latch_q[gp] <= SFR_REQ.wdata & WMSK;
        end else if (latch_bit_wr[gp]) begin
          latch_q[gp] <= SFR_REQ.wdata[0] ? (latch_q[gp] | bit_onehot)
                                          : (latch_q[gp] & ~bit_onehot);
        end
      end

      // output mode per pin; port 4 bit 7 has no pad and stays open drain
      always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
          drive_q[gp] <= plm_pkg::DRIVE_RESET;
        end else if (drive_wr[gp]) begin
          drive_q[gp] <= SFR_REQ.wdata & WMSK;
        end
      end

      // input kind per pin; port 4 bit 7 is held digital, it has no pin to switch
      always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
          kind_q[gp] <= plm_pkg::KIND_RESET;
        end else if (kind_wr[gp]) begin
          kind_q[gp] <= SFR_REQ.wdata | ~WMSK;
        end
      end

      // analog pins have their receiver off and read zero
      assign pin_view[gp] = PIN_IN[gp*8 +: 8] & kind_q[gp] & WMSK;
      assign DIGITAL_IN_EN[gp*8 +: 8] = kind_q[gp];
      // open drain only pulls low; drivers off until the assigner is on
      assign PAD.out[gp*8 +: 8] = latch_q[gp];
      assign PAD.oe[gp*8 +: 8]  = assign_q[plm_pkg::PIN_ASSIGNER_BIT] ?
                                  ((~latch_q[gp] | drive_q[gp]) & kind_q[gp] & WMSK)
                                  : 8'h00;
    end
  endgenerate

  // skip bits for ports 0 to 3
  genvar gs;
  generate
    for (gs = 0; gs < 4; gs++) begin : g_skip
      localparam logic [7:0] SADDR = (gs == 3) ? plm_pkg::PORT3_SKIP_ADDR :
                                     8'(plm_pkg::PORT0_SKIP_ADDR + 8'(gs));
      // skip register strobe
      assign skip_wr[gs] = SFR_REQ.wr && (SFR_REQ.addr == SADDR);

      // skip bits only steer the crossbar; the pin itself is untouched here
      always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
          skip_q[gs] <= plm_pkg::SKIP_RESET;
        end else if (skip_wr[gs]) begin
          skip_q[gs] <= SFR_REQ.wdata;
        end
      end
      assign CROSSBAR_SKIP[gs*8 +: 8] = skip_q[gs];
    end
  endgenerate

  // compare value and mask for ports 0 to 2
  genvar gm;
  generate
    for (gm = 0; gm < 3; gm++) begin : g_match
      assign cmp_val_wr[gm] = SFR_REQ.wr &&
                              (SFR_REQ.addr == 8'(plm_pkg::CMP_VALUE0_ADDR + 8'(gm)));
      assign cmp_msk_wr[gm] = SFR_REQ.wr &&
                              (SFR_REQ.addr == 8'(plm_pkg::CMP_MASK0_ADDR + 8'(gm)));

      // compare value; reset mask of zero keeps the event quiet until software arms it
      always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
          cmp_val_q[gm] <= plm_pkg::CMP_VALUE_RESET;
        end else if (cmp_val_wr[gm]) begin
          cmp_val_q[gm] <= SFR_REQ.wdata;
        end
      end

      // compare mask; a zero bit drops that pin out of the comparison
      always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
          cmp_msk_q[gm] <= plm_pkg::CMP_MASK_RESET;
        end else if (cmp_msk_wr[gm]) begin
          cmp_msk_q[gm] <= SFR_REQ.wdata;
        end
      end
      // compares what a read would see, so analog pins count as zero
      assign mismatch[gm] = (pin_view[gm] & cmp_msk_q[gm]) !=
                            (cmp_val_q[gm] & cmp_msk_q[gm]);
    end
  endgenerate

  // control register strobes
  assign assign_wr = SFR_REQ.wr && (SFR_REQ.addr == plm_pkg::PIN_ASSIGN_ADDR);
  assign irq_en_wr = SFR_REQ.wr && (SFR_REQ.addr == plm_pkg::IRQ_ENABLE_ADDR);

  // pin assigner register; its enable bit gates every output driver
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      assign_q <= plm_pkg::CTRL_RESET;
    end else if (assign_wr) begin
      assign_q <= SFR_REQ.wdata;
    end
  end

  // interrupt enable register; only the pattern event bit is used here
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      irq_en_q <= plm_pkg::CTRL_RESET;
    end else if (irq_en_wr) begin
      irq_en_q <= SFR_REQ.wdata;
    end
  end

  // any of ports 0 to 2 out of step with its masked compare value
  assign match_any = |mismatch;

  // event is a level: it lasts while the pins differ, no sticky flag here
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      PORT_MATCH <= 1'b0;
    end else begin
      PORT_MATCH <= match_any;
    end
  end

  // interrupt request follows the event only while enabled
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      PATTERN_IRQ <= 1'b0;
    end else begin
      PATTERN_IRQ <= match_any & irq_en_q[plm_pkg::PATTERN_IRQ_BIT];
    end
  end

  // wake ignores the enable so a masked interrupt can still rouse the oscillator
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      OSC_WAKE <= 1'b0;
    end else begin
      OSC_WAKE <= match_any;
    end
  end

  assign PIN_ASSIGNER_ON = assign_q[plm_pkg::PIN_ASSIGNER_BIT];

  // read mux; rmw read takes the latch so untouched bits keep their value
  always_comb begin
    rdata_d = 8'h00;
    hit_d   = 1'b1;
    case (SFR_REQ.addr)
      plm_pkg::PORT0_LATCH_ADDR: rdata_d = SFR_REQ.rmw ? latch_q[0] : pin_view[0];
      plm_pkg::PORT1_LATCH_ADDR: rdata_d = SFR_REQ.rmw ? latch_q[1] : pin_view[1];
      plm_pkg::PORT2_LATCH_ADDR: rdata_d = SFR_REQ.rmw ? latch_q[2] : pin_view[2];
      plm_pkg::PORT3_LATCH_ADDR: rdata_d = SFR_REQ.rmw ? latch_q[3] : pin_view[3];
      plm_pkg::PORT4_LATCH_ADDR: rdata_d = (SFR_REQ.rmw ? latch_q[4] : pin_view[4])
                                           & plm_pkg::PORT4_WRITE_MASK;
      plm_pkg::PORT0_SKIP_ADDR:  rdata_d = skip_q[0];
      plm_pkg::PORT1_SKIP_ADDR:  rdata_d = skip_q[1];
      plm_pkg::PORT2_SKIP_ADDR:  rdata_d = skip_q[2];
      plm_pkg::PORT3_SKIP_ADDR:  rdata_d = skip_q[3];
      plm_pkg::PIN_ASSIGN_ADDR:  rdata_d = assign_q;
      plm_pkg::IRQ_ENABLE_ADDR:  rdata_d = irq_en_q;
      default: begin
        hit_d = 1'b0;
        for (int i = 0; i < NP; i++) begin
          if (SFR_REQ.addr == 8'(plm_pkg::DRIVE0_ADDR + 8'(i))) begin
            rdata_d = drive_q[i];
            hit_d   = 1'b1;
          end
          if (SFR_REQ.addr == 8'(plm_pkg::KIND0_ADDR + 8'(i))) begin
            rdata_d = kind_q[i];
            hit_d   = 1'b1;
          end
        end
        for (int j = 0; j < 3; j++) begin
          if (SFR_REQ.addr == 8'(plm_pkg::CMP_VALUE0_ADDR + 8'(j))) begin
            rdata_d = cmp_val_q[j];
            hit_d   = 1'b1;
          end
          if (SFR_REQ.addr == 8'(plm_pkg::CMP_MASK0_ADDR + 8'(j))) begin
            rdata_d = cmp_msk_q[j];
            hit_d   = 1'b1;
          end
        end
      end
    endcase
  end

  // read data registered one cycle after the strobe, then held until the next read
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      SFR_RDATA <= plm_pkg::RDATA_RESET;
    end else if (rd_any) begin
      SFR_RDATA <= rdata_d;
    end
  end

  // hit lasts one cycle; an unmapped read answers zero with no hit
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      SFR_HIT <= 1'b0;
    end else begin
      SFR_HIT <= rd_any & hit_d;
    end
  end

endmodule
`default_nettype wire

/* File: sim/plm_pin_board.sv */
// partner: pads and board as seen from the port pins
`timescale 1ns/1ps
`default_nettype none
module plm_pin_board (
  input  wire plm_pkg::plm_pad_t pad,
  input  wire logic [39:0]       ext_en,
  input  wire logic [39:0]       ext_val,
  output logic [39:0]            pin
);
  // device drive wins; a released pin falls back to the weak pullup
  always_comb begin
    pin = (pad.oe & pad.out) | (~pad.oe & ((ext_en & ext_val) | ~ext_en));
  end
endmodule
`default_nettype wire

/* File: sim/plm_chk_assertions.sv */
// checker: port relations of the port latch and match block
`timescale 1ns/1ps
`default_nettype none
module plm_chk (
  input wire logic                  SYS_CLK,
  input wire logic                  RST_B,
  input wire plm_pkg::plm_sfr_req_t SFR_REQ,
  input wire logic [7:0]            SFR_RDATA,
  input wire logic                  SFR_HIT,
  input wire plm_pkg::plm_pad_t     PAD,
  input wire logic [39:0]           DIGITAL_IN_EN,
  input wire logic                  PIN_ASSIGNER_ON,
  input wire logic                  PORT_MATCH,
  input wire logic                  PATTERN_IRQ,
  input wire logic                  OSC_WAKE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  wire logic       rq = SFR_REQ.rd | SFR_REQ.rmw;
  wire logic [7:0] a  = SFR_REQ.addr;
  drv_off_a: assert property (!PIN_ASSIGNER_ON |-> PAD.oe == 40'h0)
    else $error("driven off");
  analog_quiet_a: assert property ((PAD.oe & ~DIGITAL_IN_EN) == 40'h0)
    else $error("analog pin driven");
  low_drive_a: assert property (PIN_ASSIGNER_ON |->
    (~PAD.out[38:0] & DIGITAL_IN_EN[38:0] & ~PAD.oe[38:0]) == 39'h0)
    else $error("zero not driven");
  latch_write_a: assert property (SFR_REQ.wr && a == plm_pkg::PORT2_LATCH_ADDR |=>
    PAD.out[23:16] == $past(SFR_REQ.wdata)) else $error("latch not written");
  p4_bit_a: assert property (SFR_REQ.bit_wr && !SFR_REQ.wr &&
    a == plm_pkg::PORT4_LATCH_ADDR |=> $stable(PAD.out[39:32]))
    else $error("port 4 took bit write");
  p4_top_a: assert property (rq && a == plm_pkg::PORT4_LATCH_ADDR |=>
    SFR_HIT && !SFR_RDATA[7] && !PAD.out[39]) else $error("port 4 top bit set");
  hit_cause_a: assert property (SFR_HIT |-> $past(rq)) else $error("hit without read");
  wake_irq_a: assert property (OSC_WAKE == PORT_MATCH && (PORT_MATCH || !PATTERN_IRQ))
    else $error("wake or irq apart from match");
  cover property (SFR_HIT && $past(SFR_REQ.rmw));
  cover property ($rose(PATTERN_IRQ));
  cover property (PIN_ASSIGNER_ON && PAD.oe != 40'h0);
endmodule
bind plm_port_latch_and_match plm_chk i_chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
  .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT), .PAD(PAD),
  .DIGITAL_IN_EN(DIGITAL_IN_EN), .PIN_ASSIGNER_ON(PIN_ASSIGNER_ON),
  .PORT_MATCH(PORT_MATCH), .PATTERN_IRQ(PATTERN_IRQ), .OSC_WAKE(OSC_WAKE));
`default_nettype wire

/* File: sim/test_plm_port_latch_and_match.sv */
// testbench: port latch and match block driven over the register bus
`timescale 1ns/1ps
`default_nettype none
module test_plm_port_latch_and_match;
  logic                  sys_clk, rst_b, hit, xon, match, irq, wake;
  plm_pkg::plm_sfr_req_t req;
  plm_pkg::plm_pad_t     pad;
  logic [7:0]            rdata, v, q[$];
  logic [39:0]           pin, ext_en, ext_val, din;
  logic [31:0]           skip;
  int                    seed, n_errors, n_checks, i;
  plm_port_latch_and_match i_dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .SFR_REQ(req),
    .SFR_RDATA(rdata), .SFR_HIT(hit), .PIN_IN(pin), .PAD(pad), .CROSSBAR_SKIP(skip),
    .DIGITAL_IN_EN(din), .PIN_ASSIGNER_ON(xon), .PORT_MATCH(match),
    .PATTERN_IRQ(irq), .OSC_WAKE(wake));
  plm_pin_board i_pins (.pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin(pin));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // k is {wr, rd, bit_wr, rmw}; dropped after the taking edge, so one idle cycle follows
  task automatic op(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d,
                    input logic [2:0] s = 3'h0);
    @(posedge sys_clk);
    #1 req = {k, a, s, d};
    @(posedge sys_clk);
    #1 req = '0;
  endtask
  task automatic rd(input logic m, input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    op(m ? 4'h1 : 4'h4, a, 8'h00);
  endtask
  // match is a level with one cycle lag; the bound only guards a stuck design
  task automatic wait_match(input logic e);
    for (i = 0; i < 8 && match !== e; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(40'(match), 40'(e));
    if (match !== e)
      test_done();
  endtask
  // each read answer meets the oldest expectation
  always @(negedge sys_clk) begin
    if (hit === 1'b1) begin
      if (q.size() == 0)
        chk(40'h1, 40'h0);
      else
        chk(40'(rdata), 40'(q.pop_front()));
    end
  end
  initial begin
    seed = 32'hbb43_aaa0;
    n_errors = 0;
    n_checks = 0;
    req = '0;
    rst_b = 1'b0;
    ext_en = 40'h0;
    ext_val = 40'h0;
    repeat (16) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    rd(1, plm_pkg::PORT2_LATCH_ADDR, 8'hFF);
    rd(1, plm_pkg::PORT4_LATCH_ADDR, 8'h7F);
    rd(0, plm_pkg::PORT3_SKIP_ADDR, 8'h00);
    rd(0, plm_pkg::PORT3_LATCH_ADDR, 8'hFF);
    op(4'h4, 8'h00, 8'h00);
    // port 2 pins driven from outside while the assigner is off
    v = 8'($random(seed));
    ext_en[23:16] = 8'hFF;
    ext_val[23:16] = v;
    op(4'h8, plm_pkg::PORT2_LATCH_ADDR, 8'h55);
    rd(0, plm_pkg::PORT2_LATCH_ADDR, v);
    rd(1, plm_pkg::PORT2_LATCH_ADDR, 8'h55);
    chk(40'(xon), 40'h0);
    op(4'h8, plm_pkg::PIN_ASSIGN_ADDR, 8'(1 << plm_pkg::PIN_ASSIGNER_BIT));
    chk(40'(xon), 40'h1);
    rd(0, plm_pkg::PORT2_LATCH_ADDR, v & 8'h55);
    ext_en[23:16] = 8'h00;
    v = 8'($random(seed));
    op(4'h8, plm_pkg::DRIVE0_ADDR, 8'hFF);
    op(4'h8, plm_pkg::PORT0_LATCH_ADDR, v);
    rd(0, plm_pkg::PORT0_LATCH_ADDR, v);
    for (int b = 0; b < 8; b++)
      op(4'h2, plm_pkg::PORT3_LATCH_ADDR, 8'(b & 1), 3'(b));
    op(4'h2, plm_pkg::PORT4_LATCH_ADDR, 8'h00);
    rd(1, plm_pkg::PORT3_LATCH_ADDR, 8'hAA);
    rd(1, plm_pkg::PORT4_LATCH_ADDR, 8'h7F);
    op(4'h8, plm_pkg::PORT4_LATCH_ADDR, 8'h80);
    rd(0, plm_pkg::PORT4_LATCH_ADDR, 8'h00);
    // upper port 0 pins become analog and are skipped
    op(4'h8, plm_pkg::PORT0_SKIP_ADDR, 8'hF0);
    op(4'h8, plm_pkg::KIND0_ADDR, 8'h0F);
    rd(0, plm_pkg::PORT0_LATCH_ADDR, v & 8'h0F);
    rd(0, plm_pkg::PORT0_SKIP_ADDR, 8'hF0);
    chk(40'(skip[7:0]), 40'hF0);
    chk(40'(din), 40'hFF_FFFF_FF0F);
    // port 1 match against a random pattern
    v = 8'($random(seed));
    ext_en[15:8] = 8'hFF;
    ext_val[15:8] = v;
    op(4'h8, plm_pkg::CMP_MASK0_ADDR + 8'h01, 8'hFF);
    op(4'h8, plm_pkg::CMP_VALUE0_ADDR + 8'h01, v);
    op(4'h8, plm_pkg::IRQ_ENABLE_ADDR, 8'(1 << plm_pkg::PATTERN_IRQ_BIT));
    wait_match(1'b0);
    ext_val[15:8] = v ^ 8'h10;
    wait_match(1'b1);
    chk(40'({irq, wake}), 40'h3);
    // with the enable cleared the request drops while wake stays
    op(4'h8, plm_pkg::IRQ_ENABLE_ADDR, 8'h00);
    @(posedge sys_clk);
    #1 chk(40'({irq, wake}), 40'h1);
    op(4'h8, plm_pkg::CMP_MASK0_ADDR + 8'h01, 8'hEF);
    wait_match(1'b0);
    repeat (3) @(posedge sys_clk);
    chk(40'(q.size()), 40'h0);
    test_done();
  end
endmodule
`default_nettype wire
